/* design/hdt_timer_address_regs.sv */
`timescale 1ns/1ps
module hdt_timer_address_regs
	import hdt_pkg::*;
#(
	parameter int VALUE_WIDTH = 24
)(
	input  wire logic       i_clock,
	input  wire logic       i_rstn,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	input  wire logic       i_clock_mode5,
	input  wire logic       i_tx_clock_tick,
	input  wire logic       i_frame_sync_input,
	input  wire logic       i_start_timer_cmd,
	input  wire logic       i_stop_timer_cmd,
	input  wire logic       i_iframe_sent,
	input  wire logic       i_iframe_acked,
	input  wire logic       i_auto_hdlc_mode,
	input  wire logic       i_auto_addr_mode,
	input  wire logic       i_address_field_size,
	input  wire logic       i_tx_is_command,
	input  wire logic       i_rx_addr_valid,
	input  wire logic [7:0] i_rx_addr_high,
	input  wire logic [7:0] i_rx_addr_low,
	input  wire logic [7:0] i_rx_mask_one_low,
	input  wire logic [7:0] i_rx_mask_one_high,
	input  wire logic [7:0] i_rx_mask_two_low,
	input  wire logic [7:0] i_rx_mask_two_high,
	output logic            o_timer_running,
	output logic            o_timer_irq,
	output logic            o_poll_request,
	output logic            o_retry_exhausted,
	output logic            o_tx_addr_insert,
	output logic            o_tx_addr_two_bytes,
	output logic      [7:0] o_tx_addr_first,
	output logic      [7:0] o_tx_addr_second,
	output logic            o_rx_result_valid,
	output logic            o_rx_addr_match,
	output logic            o_rx_cr_status
);

	logic [7:0] timer_period_low_ff;
	logic [7:0] timer_period_mid_ff;
	logic [7:0] timer_period_high_ff;
	logic [7:0] timer_config_ff;
	logic [7:0] tx_address_first_ff;
	logic [7:0] tx_address_second_ff;
	logic [7:0] rx_address_one_low_ff;
	logic [7:0] rx_address_one_high_ff;
	logic [7:0] rx_address_two_low_ff;
	logic [7:0] rx_address_two_high_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	logic       timer_clock_select;
	logic       timer_protocol_select;
	logic [2:0] repeat_count;
	logic       cr_polarity_select;
	logic       timer_tick;
	logic       timer_start;
	logic       timer_stop;
	logic       timer_expire;
	logic       timer_last;

	// Register write port; reserved configuration bits never store.
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			timer_period_low_ff    <= HDT_RESET_BYTE;
			timer_period_mid_ff    <= HDT_RESET_BYTE;
			timer_period_high_ff   <= HDT_RESET_BYTE;
			timer_config_ff        <= HDT_RESET_BYTE;
			tx_address_first_ff    <= HDT_RESET_BYTE;
			tx_address_second_ff   <= HDT_RESET_BYTE;
			rx_address_one_low_ff  <= HDT_RESET_BYTE;
			rx_address_one_high_ff <= HDT_RESET_BYTE;
			rx_address_two_low_ff  <= HDT_RESET_BYTE;
			rx_address_two_high_ff <= HDT_RESET_BYTE;
		end
		else if (i_reg_wr)
		begin
			case (i_reg_addr)
				HDT_OFF_TIMER_LOW:   timer_period_low_ff    <= i_reg_wdata;
				HDT_OFF_TIMER_MID:   timer_period_mid_ff    <= i_reg_wdata;
				HDT_OFF_TIMER_HIGH:  timer_period_high_ff   <= i_reg_wdata;
				HDT_OFF_TIMER_CFG:
					timer_config_ff <= i_reg_wdata & HDT_CFG_WRITE_MASK;
				HDT_OFF_TX_FIRST:    tx_address_first_ff    <= i_reg_wdata;
				HDT_OFF_TX_SECOND:   tx_address_second_ff   <= i_reg_wdata;
				HDT_OFF_RX_ONE_LOW:  rx_address_one_low_ff  <= i_reg_wdata;
				HDT_OFF_RX_ONE_HIGH: rx_address_one_high_ff <= i_reg_wdata;
				HDT_OFF_RX_TWO_LOW:  rx_address_two_low_ff  <= i_reg_wdata;
				HDT_OFF_RX_TWO_HIGH: rx_address_two_high_ff <= i_reg_wdata;
				default:             ;
			endcase
		end
	end

	// Unmapped offsets read as zero.
	always_comb
	begin
		case (i_reg_addr)
			HDT_OFF_TIMER_LOW:   nxt_rdata = timer_period_low_ff;
			HDT_OFF_TIMER_MID:   nxt_rdata = timer_period_mid_ff;
			HDT_OFF_TIMER_HIGH:  nxt_rdata = timer_period_high_ff;
			HDT_OFF_TIMER_CFG:   nxt_rdata = timer_config_ff;
			HDT_OFF_TX_FIRST:    nxt_rdata = tx_address_first_ff;
			HDT_OFF_TX_SECOND:   nxt_rdata = tx_address_second_ff;
			HDT_OFF_RX_ONE_LOW:  nxt_rdata = rx_address_one_low_ff;
			HDT_OFF_RX_ONE_HIGH: nxt_rdata = rx_address_one_high_ff;
			HDT_OFF_RX_TWO_LOW:  nxt_rdata = rx_address_two_low_ff;
			HDT_OFF_RX_TWO_HIGH: nxt_rdata = rx_address_two_high_ff;
			default:             nxt_rdata = HDT_RESET_BYTE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			rdata_ff <= HDT_RESET_BYTE;
		else if (i_reg_rd)
			rdata_ff <= nxt_rdata;
	end

	assign o_reg_rdata = rdata_ff;

	assign timer_clock_select    = timer_config_ff[HDT_CFG_SRC_BIT];
	assign timer_protocol_select = timer_config_ff[HDT_CFG_TMD_BIT];
	assign repeat_count          = timer_config_ff[2:0];

	// The polarity bit only exists while automatic HDLC mode runs.
	assign cr_polarity_select = i_auto_hdlc_mode &&
		rx_address_one_high_ff[HDT_CR_BIT];

	// Frame-sync clocking is honoured in clock mode 5 only.
	assign timer_tick = (timer_clock_select && i_clock_mode5) ?
		i_frame_sync_input :
		i_tx_clock_tick;

	// With timer mode 1 the CPU commands are ignored; the protocol
	// engine arms the timer on each I-frame and clears it on the ack.
	assign timer_start = timer_protocol_select ?
		i_iframe_sent : i_start_timer_cmd;
	assign timer_stop  = timer_protocol_select ?
		i_iframe_acked : i_stop_timer_cmd;

	hdt_timer #(
		.VALUE_WIDTH (VALUE_WIDTH)
	) u_timer (
		.i_clock        (i_clock),
		.i_rstn         (i_rstn),
		.i_tick         (timer_tick),
		.i_start        (timer_start),
		.i_stop         (timer_stop),
		.i_expiry_value (VALUE_WIDTH'({timer_period_high_ff,
			timer_period_mid_ff, timer_period_low_ff})),
		.i_repeat_count (repeat_count),
		.o_running      (o_timer_running),
		.o_expire       (timer_expire),
		.o_last         (timer_last)
	);

	// The same restart budget serves as the retry budget: every expiry
	// with budget left asks for one polled S-command frame.
	assign o_timer_irq       = timer_expire &&
		!timer_protocol_select;
	assign o_poll_request    = timer_expire && timer_protocol_select &&
		!timer_last;
	assign o_retry_exhausted = timer_expire && timer_protocol_select &&
		timer_last;

	// Transmit address field, refreshed every cycle from the registers while automatic address mode is on.
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_tx_addr_insert    <= 1'b0;
			o_tx_addr_two_bytes <= 1'b0;
			o_tx_addr_first     <= HDT_RESET_BYTE;
			o_tx_addr_second    <= HDT_RESET_BYTE;
		end
		else if (!i_auto_addr_mode)
		begin
			o_tx_addr_insert    <= 1'b0;
			o_tx_addr_two_bytes <= 1'b0;
			o_tx_addr_first     <= HDT_RESET_BYTE;
			o_tx_addr_second    <= HDT_RESET_BYTE;
		end
		else if (i_address_field_size)
		begin
			o_tx_addr_insert    <= 1'b1;
			o_tx_addr_two_bytes <= 1'b1;
			o_tx_addr_first     <= tx_address_first_ff;
			o_tx_addr_first[HDT_CR_BIT] <= i_tx_is_command ?
				cr_polarity_select : !cr_polarity_select;
			o_tx_addr_second    <= tx_address_second_ff;
		end
		else
		begin
			o_tx_addr_insert    <= 1'b1;
			o_tx_addr_two_bytes <= 1'b0;
			o_tx_addr_first     <= i_tx_is_command ?
				tx_address_first_ff : tx_address_second_ff;
			o_tx_addr_second    <= HDT_RESET_BYTE;
		end
	end

	logic [7:0] one_high_mask;
	logic       match_one;
	logic       match_two;
	logic       rx_is_command;

	// The received C/R bit varies with frame direction, so it is masked
	// from the address one comparison while automatic HDLC mode runs.
	assign one_high_mask = i_rx_mask_one_high |
		{6'h00, i_auto_hdlc_mode, 1'b0};

	always_comb
	begin
		if (i_address_field_size)
		begin
			match_one = hdt_byte_match(i_rx_addr_high,
				rx_address_one_high_ff, one_high_mask) &&
				hdt_byte_match(i_rx_addr_low, rx_address_one_low_ff,
				i_rx_mask_one_low);
			match_two = hdt_byte_match(i_rx_addr_high,
				rx_address_two_high_ff, i_rx_mask_two_high) &&
				hdt_byte_match(i_rx_addr_low, rx_address_two_low_ff,
				i_rx_mask_two_low);
			rx_is_command = (i_rx_addr_high[HDT_CR_BIT] !=
				cr_polarity_select);
		end
		else
		begin
			match_one = hdt_byte_match(i_rx_addr_low,
				rx_address_one_low_ff, i_rx_mask_one_low);
			match_two = hdt_byte_match(i_rx_addr_low,
				rx_address_two_low_ff, i_rx_mask_two_low);
			rx_is_command = match_one;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_rx_result_valid <= 1'b0;
			o_rx_addr_match   <= 1'b0;
			o_rx_cr_status    <= 1'b0;
		end
		else
		begin
			o_rx_result_valid <= i_rx_addr_valid;
			if (i_rx_addr_valid)
			begin
				o_rx_addr_match <= !i_auto_addr_mode ||
					match_one || match_two;
				o_rx_cr_status  <= rx_is_command ?
					!cr_polarity_select : cr_polarity_select;
			end
		end
	end

	tx_cr_bit_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$past(i_auto_addr_mode) && $past(i_address_field_size) |->
		o_tx_addr_first[HDT_CR_BIT] ==
		($past(i_tx_is_command) ~^ $past(cr_polarity_select)))
		else $error("transmit C/R bit has wrong polarity");

	tx_one_byte_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$past(i_auto_addr_mode) && !$past(i_address_field_size) |->
		o_tx_addr_first == ($past(i_tx_is_command) ?
		$past(tx_address_first_ff) : $past(tx_address_second_ff)))
		else $error("one-byte transmit address picked wrong register");

	rx_mask_all_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		i_rx_addr_valid && (&i_rx_mask_one_low) &&
		((&i_rx_mask_one_high) || !i_address_field_size) |=>
		o_rx_result_valid && o_rx_addr_match)
		else $error("fully masked address was rejected");

	irq_mode_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		o_timer_irq |-> !timer_protocol_select && !o_poll_request)
		else $error("timer interrupt raised in protocol timer mode");

	poll_mode_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		o_poll_request |-> timer_protocol_select && !o_retry_exhausted)
		else $error("poll request outside automatic timer mode");

	rx_valid_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		i_rx_addr_valid |=> o_rx_result_valid)
		else $error("receive address result missing");

	// A one-byte address that differs from both registers in an unmasked
	// position must be turned away.
	rx_unmasked_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		i_rx_addr_valid && i_auto_addr_mode && !i_address_field_size &&
		|((i_rx_addr_low ^ rx_address_one_low_ff) & ~i_rx_mask_one_low) &&
		|((i_rx_addr_low ^ rx_address_two_low_ff) & ~i_rx_mask_two_low)
		|=> !o_rx_addr_match)
		else $error("unmasked address difference was accepted");

	tx_low_byte_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$past(i_auto_addr_mode) && $past(i_address_field_size) |->
		o_tx_addr_second == $past(tx_address_second_ff))
		else $error("two-byte transmit low byte is wrong");

endmodule

/* design/hdt_pkg.sv */
package hdt_pkg;

	localparam logic [7:0] HDT_OFF_TIMER_LOW   = 8'h3a;
	localparam logic [7:0] HDT_OFF_TIMER_MID   = 8'h3b;
	localparam logic [7:0] HDT_OFF_TIMER_HIGH  = 8'h3c;
	localparam logic [7:0] HDT_OFF_TIMER_CFG   = 8'h3d;
	localparam logic [7:0] HDT_OFF_TX_FIRST    = 8'h3e;
	localparam logic [7:0] HDT_OFF_TX_SECOND   = 8'h3f;
	localparam logic [7:0] HDT_OFF_RX_ONE_LOW  = 8'h40;
	localparam logic [7:0] HDT_OFF_RX_ONE_HIGH = 8'h41;
	localparam logic [7:0] HDT_OFF_RX_TWO_LOW  = 8'h42;
	localparam logic [7:0] HDT_OFF_RX_TWO_HIGH = 8'h43;

	localparam logic [7:0] HDT_RESET_BYTE      = 8'h00;
	localparam logic [7:0] HDT_CFG_WRITE_MASK  = 8'h97;

	localparam int         HDT_CFG_SRC_BIT     = 7;
	localparam int         HDT_CFG_TMD_BIT     = 4;
	localparam int         HDT_CR_BIT          = 1;

	localparam logic [2:0] HDT_COUNT_UNLIMITED = 3'h7;
	localparam logic [2:0] HDT_COUNT_NONE      = 3'h0;

	typedef enum logic [0:0] {
		HDT_IDLE = 1'b0,
		HDT_RUN  = 1'b1
	} hdt_timer_e;

	// A position matches when equal or when its mask bit is set.
	function automatic logic hdt_byte_match(
		input logic [7:0] rx,
		input logic [7:0] prog,
		input logic [7:0] mask
	);
		hdt_byte_match = &(~(rx ^ prog) | mask);
	endfunction

endpackage

/* design/hdt_timer.sv */
`timescale 1ns/1ps
module hdt_timer
	import hdt_pkg::*;
#(
	parameter int VALUE_WIDTH = 24
)(
	input  wire logic                   i_clock,
	input  wire logic                   i_rstn,
	input  wire logic                   i_tick,
	input  wire logic                   i_start,
	input  wire logic                   i_stop,
	input  wire logic [VALUE_WIDTH-1:0] i_expiry_value,
	input  wire logic [2:0]             i_repeat_count,
	output logic                        o_running,
	output logic                        o_expire,
	output logic                        o_last
);

	hdt_timer_e             state_ff;
	logic [VALUE_WIDTH-1:0] count_ff;
	logic [2:0]             left_ff;
	logic                   expire_ff;
	logic                   last_ff;
	logic                   hit;
	logic                   nxt_expire;

	assign hit        = (count_ff == i_expiry_value);
	assign nxt_expire = !i_stop && !i_start && (state_ff == HDT_RUN) &&
		i_tick && hit;

	// Stop outranks start so a stale start cannot revive a halted timer.
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_ff <= HDT_IDLE;
			left_ff  <= HDT_COUNT_NONE;
		end
		else
		begin
			case (state_ff)
				HDT_IDLE:
				begin
					if (!i_stop && i_start)
					begin
						state_ff <= HDT_RUN;
						left_ff  <= i_repeat_count;
					end
				end
				HDT_RUN:
				begin
					if (i_stop)
						state_ff <= HDT_IDLE;
					else if (i_start)
						left_ff <= i_repeat_count;
					else if (nxt_expire)
					begin
						if (left_ff == HDT_COUNT_NONE)
							state_ff <= HDT_IDLE;
						else if (left_ff != HDT_COUNT_UNLIMITED)
							left_ff <= left_ff - 3'h1;
					end
				end
				default:
					state_ff <= HDT_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			count_ff <= '0;
		else if (i_stop || i_start)
			count_ff <= '0;
		else if (state_ff == HDT_RUN && i_tick)
			count_ff <= hit ? '0 : count_ff + 1'b1;
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			expire_ff <= 1'b0;
			last_ff   <= 1'b0;
		end
		else
		begin
			expire_ff <= nxt_expire;
			last_ff   <= nxt_expire && (left_ff == HDT_COUNT_NONE);
		end
	end

	assign o_running = (state_ff == HDT_RUN);
	assign o_expire  = expire_ff;
	assign o_last    = last_ff;

	period_hit_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		o_expire |-> $past(i_tick) && $past(count_ff) == $past(i_expiry_value))
		else $error("timer expired before reaching the expiry value");

	stop_halts_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		i_stop |=> !o_running && !o_expire)
		else $error("timer still running after stop");

	start_runs_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		i_start && !i_stop |=> o_running && count_ff == '0)
		else $error("timer did not start on command");

	restart_count_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		o_expire |-> (o_running == !o_last))
		else $error("restart decision wrong after expiry");

	unlimited_a: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		o_running && left_ff == HDT_COUNT_UNLIMITED && !i_stop && !i_start
		|=> o_running && !o_last)
		else $error("unlimited count stopped the timer");

endmodule

/* dv/hdt_line_model.sv */
`timescale 1ns/1ps
module hdt_line_model #(
	parameter int TX_DIV = 3,
	parameter int FS_DIV = 7
)(
	input  wire logic i_clock,
	input  wire logic i_rstn,
	output logic      o_tx_clock_tick,
	output logic      o_frame_sync_input
);
	int tx_cnt = 0;
	int fs_cnt = 0;

	initial
	begin
		o_tx_clock_tick = 1'h0;
		o_frame_sync_input = 1'h0;
	end

	// Ticks come at least three cycles apart, so that an expiry pulse never
	// shares its cycle with a tick and the per-period count stays exact.
	always
	begin
		@(posedge i_clock);
		#1;
		tx_cnt = (!i_rstn || tx_cnt == TX_DIV - 1) ? 0 : tx_cnt + 1;
		fs_cnt = (!i_rstn || fs_cnt == FS_DIV - 1) ? 0 : fs_cnt + 1;
		o_tx_clock_tick = i_rstn && tx_cnt == 0;
		o_frame_sync_input = i_rstn && fs_cnt == 0;
	end
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench import hdt_pkg::*;;
	logic       i_clock = 0, i_rstn = 0, i_reg_wr = 0, i_reg_rd = 0;
	logic [7:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
	logic       i_clock_mode5 = 0, i_tx_clock_tick, i_frame_sync_input;
	logic       i_start_timer_cmd = 0, i_stop_timer_cmd = 0;
	logic       i_iframe_sent = 0, i_iframe_acked = 0;
	logic       i_auto_hdlc_mode = 0, i_auto_addr_mode = 0;
	logic       i_address_field_size = 0, i_tx_is_command = 0;
	logic       i_rx_addr_valid = 0;
	logic [7:0] i_rx_addr_high = 0, i_rx_addr_low = 0;
	logic [7:0] i_rx_mask_one_low = 0, i_rx_mask_one_high = 0;
	logic [7:0] i_rx_mask_two_low = 0, i_rx_mask_two_high = 0;
	logic       o_timer_running, o_timer_irq, o_poll_request;
	logic       o_retry_exhausted, o_tx_addr_insert, o_tx_addr_two_bytes;
	logic [7:0] o_tx_addr_first, o_tx_addr_second;
	logic       o_rx_result_valid, o_rx_addr_match, o_rx_cr_status;
	logic [7:0] exp_first;
	logic       exp_two;
	logic       fs_src = 0;
	int         errors = 0, compares = 0, ticks = 0, exp_ticks = 0;
	int         expiries = 0, polls = 0, spent = 0;

	always #50 i_clock = ~i_clock;

	hdt_timer_address_regs u_hdt_timer_address_regs (
		.i_clock, .i_rstn, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
		.o_reg_rdata, .i_clock_mode5, .i_tx_clock_tick, .i_frame_sync_input,
		.i_start_timer_cmd, .i_stop_timer_cmd, .i_iframe_sent,
		.i_iframe_acked, .i_auto_hdlc_mode, .i_auto_addr_mode,
		.i_address_field_size, .i_tx_is_command, .i_rx_addr_valid,
		.i_rx_addr_high, .i_rx_addr_low, .i_rx_mask_one_low,
		.i_rx_mask_one_high, .i_rx_mask_two_low, .i_rx_mask_two_high,
		.o_timer_running, .o_timer_irq, .o_poll_request, .o_retry_exhausted,
		.o_tx_addr_insert, .o_tx_addr_two_bytes, .o_tx_addr_first,
		.o_tx_addr_second, .o_rx_result_valid, .o_rx_addr_match,
		.o_rx_cr_status
	);

	hdt_line_model u_hdt_line_model (
		.i_clock, .i_rstn, .o_tx_clock_tick(i_tx_clock_tick),
		.o_frame_sync_input(i_frame_sync_input)
	);

	task automatic finish_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic step(input int n = 1);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Each access leaves one idle edge behind it so strobes never toggle
	// twice in one time step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'h1;
		step();
		i_reg_wr = 1'h0;
		step();
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		i_reg_addr = a;
		i_reg_rd = 1'h1;
		step();
		i_reg_rd = 1'h0;
		check("register read", o_reg_rdata, exp);
		step();
	endtask

	task automatic pulse(ref logic s);
		ticks = 0;
		s = 1'h1;
		step();
		s = 1'h0;
		step();
	endtask

	task automatic timer_set(input logic [7:0] cfg, input logic [23:0] v);
		wr(HDT_OFF_TIMER_LOW, v[7:0]);
		wr(HDT_OFF_TIMER_MID, v[15:8]);
		wr(HDT_OFF_TIMER_HIGH, v[23:16]);
		wr(HDT_OFF_TIMER_CFG, cfg);
		exp_ticks = int'(v) + 1;
		expiries = 0;
		polls = 0;
		spent = 0;
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 500 && o_timer_running !== 1'h0; i++)
			step();
		check("timer stopped", o_timer_running, 1'h0);
		// The last expiry pulse stands in the same cycle in which the timer falls.
		step();
	endtask

	task automatic rx(input logic [2:0] md, input logic [7:0] mh, ml, h, l,
		input logic m, input logic [1:0] cr);
		{i_auto_addr_mode, i_address_field_size, i_auto_hdlc_mode} = md;
		i_rx_mask_one_high = mh;
		i_rx_mask_two_high = mh;
		i_rx_mask_one_low = ml;
		i_rx_mask_two_low = ml;
		i_rx_addr_high = h;
		i_rx_addr_low = l;
		i_rx_addr_valid = 1'h1;
		step();
		i_rx_addr_valid = 1'h0;
		check("rx valid", o_rx_result_valid, 1'h1);
		check("rx match", o_rx_addr_match, m);
		if (cr[1])
			check("rx cr", o_rx_cr_status, cr[0]);
		step();
	endtask

	// Every period end is checked against the ticks of the selected source.
	// Sampling mid-cycle sees each output after it has settled.
	always @(negedge i_clock)
	begin
		if (o_timer_irq === 1'h1 || o_poll_request === 1'h1
			|| o_retry_exhausted === 1'h1)
		begin
			check("ticks", ticks, exp_ticks);
			ticks = 0;
			expiries += int'(o_timer_irq);
			polls += int'(o_poll_request);
			spent += int'(o_retry_exhausted);
		end
		else if (o_timer_running === 1'h1
			&& (fs_src ? i_frame_sync_input : i_tx_clock_tick) === 1'h1)
			ticks++;
	end

	initial
	begin
		#1_000_000;
		errors++;
		finish_test();
	end

	initial
	begin
		step(20);
		i_rstn = 1'h1;
		step();
		for (logic [7:0] a = 8'h39; a <= 8'h44; a++)
		begin
			rdchk(a, 8'h00);
			wr(a, a ^ 8'hff);
			rdchk(a, (a == 8'h39 || a == 8'h44) ? 8'h00 : (a ^ 8'hff)
				& (a == HDT_OFF_TIMER_CFG ? HDT_CFG_WRITE_MASK : 8'hff));
		end
		$display("test registers done");
		timer_set(8'h02, 24'h000002);
		pulse(i_start_timer_cmd);
		check("running", o_timer_running, 1'h1);
		wait_idle();
		step(30);
		check("restarts", expiries, 3);
		timer_set(8'h07, 24'h000001);
		pulse(i_start_timer_cmd);
		for (int i = 0; i < 200 && expiries < 4; i++)
			step();
		pulse(i_stop_timer_cmd);
		check("stopped", o_timer_running, 1'h0);
		pulse(i_iframe_sent);
		step(40);
		check("periodic", expiries, 4);
		for (int k = 0; k < 2; k++)
		begin
			i_clock_mode5 = k[0];
			fs_src = k[0];
			timer_set(8'h80, 24'h000001 + 24'(k));
			pulse(i_start_timer_cmd);
			wait_idle();
			check("one shot", expiries, 1);
		end
		i_clock_mode5 = 1'h0;
		fs_src = 1'h0;
		$display("test timer mode 0 done");
		i_auto_hdlc_mode = 1'h1;
		timer_set(8'h12, 24'h000002);
		pulse(i_start_timer_cmd);
		check("cpu start ignored", o_timer_running, 1'h0);
		pulse(i_iframe_sent);
		wait_idle();
		check("polls", polls, 2);
		check("exhausted", spent, 1);
		pulse(i_iframe_sent);
		pulse(i_iframe_acked);
		step(30);
		check("acked", o_timer_running, 1'h0);
		check("no poll", polls, 2);
		wr(HDT_OFF_TIMER_CFG, 8'h00);
		$display("test timer mode 1 done");
		wr(HDT_OFF_TX_FIRST, 8'ha4);
		wr(HDT_OFF_TX_SECOND, 8'h5c);
		for (int v = 0; v < 16; v++)
		begin
			{i_auto_addr_mode, i_address_field_size} = 2'(v >> 2);
			i_tx_is_command = v[0];
			exp_two = i_auto_addr_mode & i_address_field_size;
			exp_first = i_address_field_size ? {6'h0, v[1], 1'h0} : 8'h00;
			wr(HDT_OFF_RX_ONE_HIGH, exp_first);
			exp_first = !i_address_field_size ? (v[0] ? 8'ha4 : 8'h5c)
				: {6'h29, ~(v[0] ^ v[1]), 1'h0};
			if (!i_auto_addr_mode)
				exp_first = 8'h00;
			step();
			check("insert", o_tx_addr_insert, i_auto_addr_mode);
			check("two bytes", o_tx_addr_two_bytes, exp_two);
			check("tx first", o_tx_addr_first, exp_first);
			check("tx low", o_tx_addr_second, {8{exp_two}} & 8'h5c);
		end
		$display("test tx address done");
		wr(HDT_OFF_RX_ONE_HIGH, 8'h00);
		wr(HDT_OFF_RX_ONE_LOW, 8'h11);
		wr(HDT_OFF_RX_TWO_LOW, 8'h22);
		wr(HDT_OFF_RX_TWO_HIGH, 8'h40);
		rx(3'h5, 8'h00, 8'h00, 8'h00, 8'h11, 1'h1, 2'h3);
		rx(3'h5, 8'h00, 8'h00, 8'h00, 8'h22, 1'h1, 2'h2);
		rx(3'h5, 8'h00, 8'h00, 8'h00, 8'h13, 1'h0, 2'h0);
		rx(3'h5, 8'h00, 8'h02, 8'h00, 8'h13, 1'h1, 2'h0);
		wr(HDT_OFF_RX_ONE_HIGH, 8'h82);
		rx(3'h6, 8'h00, 8'h00, 8'h82, 8'h11, 1'h1, 2'h0);
		rx(3'h6, 8'h00, 8'h00, 8'h80, 8'h11, 1'h0, 2'h0);
		rx(3'h6, 8'h01, 8'h00, 8'h83, 8'h11, 1'h1, 2'h0);
		rx(3'h6, 8'hff, 8'hff, 8'h00, 8'h00, 1'h1, 2'h0);
		rx(3'h6, 8'h00, 8'h00, 8'h40, 8'h22, 1'h1, 2'h0);
		rx(3'h7, 8'h00, 8'h00, 8'h80, 8'h11, 1'h1, 2'h2);
		rx(3'h2, 8'h00, 8'h00, 8'h55, 8'h66, 1'h1, 2'h0);
		$display("test rx address done");
		finish_test();
	end
endmodule
